/* File: mbcr_regs.vh */
// Constants for the MIDI bank controller router: register offsets, field positions and reset values.
`ifndef MBCR_REGS_VH
`define MBCR_REGS_VH
`define MBCR_ADDR_W 8
// Register word offsets (byte addresses, one word each).
`define MBCR_R_CTRL 8'h00
`define MBCR_R_CHAN 8'h04
`define MBCR_R_SLOTSEL 8'h08
`define MBCR_R_SLOTCC 8'h0c
`define MBCR_R_ROUTE_AMT 8'h10
`define MBCR_R_KNOBMAP 8'h14
`define MBCR_R_KNOBVAL 8'h18
`define MBCR_R_SLOTOUT 8'h1c
`define MBCR_R_BANK 8'h20
`define MBCR_R_PROG 8'h24
`define MBCR_R_MIXOUT 8'h28
`define MBCR_R_LAYERSEL 8'h2c
`define MBCR_R_LAYERVAL 8'h30
`define MBCR_R_JUMP 8'h34
`define MBCR_R_NAME 8'h38
`define MBCR_R_FIXED 8'h3c
`define MBCR_R_PRESET 8'h40
// CTRL fields.
`define MBCR_CTRL_EDIT 0
`define MBCR_CTRL_ALLEN 1
// MIDI status nibbles and fixed controller numbers.
`define MBCR_ST_CC 4'hb
`define MBCR_ST_PC 4'hc
`define MBCR_ST_PB 4'he
`define MBCR_CC_BANK_MSB 7'h00
`define MBCR_CC_MOD 7'h01
`define MBCR_CC_PEDAL 7'h04
`define MBCR_CC_VOL 7'h07
`define MBCR_CC_PAN 7'h0a
`define MBCR_CC_EXPR 7'h0b
`define MBCR_CC_BANK_LSB 7'h20
// Bank decode.
`define MBCR_MSB_USER 7'h00
`define MBCR_MSB_ROM 7'h12
`define MBCR_LSB_MAX 7'h03
// Mix output code that defers to the preset's layer routing.
`define MBCR_MIX_PRESET 3'h4
// Knob slot ceiling (A..L) and reset values.
`define MBCR_KNOB_SLOT_MAX 4'hb
`define MBCR_RST_VOL 7'h64
`define MBCR_RST_PAN 7'h40
`define MBCR_RST_EXPR 7'h7f
`endif

/* File: mbcr_msg_parser.v */
// MIDI byte stream parser producing complete channel messages.
`timescale 1ns/100ps
`default_nettype none
`include "mbcr_regs.vh"
module mbcr_msg_parser (
    input wire mclk_i,
    input wire resetn_i,
    input wire byte_valid_i,
    input wire [7:0] byte_i,
    output reg msg_valid_o,
    output reg [3:0] msg_status_o,
    output reg [3:0] msg_chan_o,
    output reg [6:0] msg_d1_o,
    output reg [6:0] msg_d2_o
);
    reg [3:0] run_st_reg;
    reg [3:0] run_ch_reg;
    reg have_d1_reg;
    reg [6:0] d1_reg;
    wire one_byte = (run_st_reg == `MBCR_ST_PC) || (run_st_reg == 4'hd);
    // Running status is kept so that keyboards omitting repeated status bytes still work.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_st_reg <= 4'h0;
            run_ch_reg <= 4'h0;
            have_d1_reg <= 1'b0;
            d1_reg <= 7'h00;
            msg_valid_o <= 1'b0;
            msg_status_o <= 4'h0;
            msg_chan_o <= 4'h0;
            msg_d1_o <= 7'h00;
            msg_d2_o <= 7'h00;
        end else begin
            msg_valid_o <= 1'b0;
            if (byte_valid_i) begin
                if (byte_i[7]) begin
                    if (byte_i[7:4] != 4'hf) begin
                        run_st_reg <= byte_i[7:4];
                        run_ch_reg <= byte_i[3:0];
                        have_d1_reg <= 1'b0;
                    end else if (!byte_i[3]) begin
                        run_st_reg <= 4'h0;
                    end
                end else if (run_st_reg[3]) begin
                    if (one_byte || have_d1_reg) begin
                        msg_valid_o <= 1'b1;
                        msg_status_o <= run_st_reg;
                        msg_chan_o <= run_ch_reg;
                        msg_d1_o <= one_byte ? byte_i[6:0] : d1_reg;
                        msg_d2_o <= one_byte ? 7'h00 : byte_i[6:0];
                        have_d1_reg <= 1'b0;
                    end else begin
                        d1_reg <= byte_i[6:0];
                        have_d1_reg <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: mbcr_jump_stepper.v */
// Sixteen jump-button page steppers with wrap to the first screen.
`timescale 1ns/100ps
`default_nettype none
`include "mbcr_regs.vh"
module mbcr_jump_stepper #(
    parameter PAGE_W = 3
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire press_i,
    input wire [3:0] button_i,
    input wire [PAGE_W-1:0] last_page_i,
    output reg [3:0] category_o,
    output reg [PAGE_W-1:0] page_o
);
    reg [PAGE_W-1:0] pos_reg [0:15];
    integer i;
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (i = 0; i < 16; i = i + 1) begin
                pos_reg[i] <= {PAGE_W{1'b0}};
            end
            category_o <= 4'h0;
            page_o <= {PAGE_W{1'b0}};
        end else if (press_i) begin
            category_o <= button_i;
            // A new category starts at its first screen; repeated presses step and wrap.
            if (category_o != button_i) begin
                pos_reg[button_i] <= {PAGE_W{1'b0}};
                page_o <= {PAGE_W{1'b0}};
            end else if (page_o >= last_page_i) begin
                pos_reg[button_i] <= {PAGE_W{1'b0}};
                page_o <= {PAGE_W{1'b0}};
            end else begin
                pos_reg[button_i] <= page_o + 1'b1;
                page_o <= page_o + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: mbcr_top.v */
// MIDI bank, controller and output routing interpreter with edit-menu register port.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mbcr_regs.vh"
module mbcr_top #(
    parameter NCH = 16,
    parameter NSLOT = 16,
    parameter NKNOB = 4,
    parameter PAGE_W = 3
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire midi_valid_i,
    input wire [7:0] midi_byte_i,
    input wire [`MBCR_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output reg fixed_valid_o,
    output reg [3:0] fixed_chan_o,
    output reg [2:0] fixed_dest_o,
    output reg [13:0] fixed_value_o,
    output reg slot_valid_o,
    output reg [3:0] slot_chan_o,
    output reg [3:0] slot_idx_o,
    output reg signed [15:0] slot_mod_o,
    output reg prog_valid_o,
    output reg [3:0] prog_chan_o,
    output reg [13:0] prog_bank_o,
    output reg [6:0] prog_num_o,
    output reg prog_rom_o,
    output reg [1:0] prog_bank_idx_o,
    output reg prog_bank_known_o,
    output wire [2:0] layer_send_o,
    output wire [3:0] jump_category_o,
    output wire [PAGE_W-1:0] jump_page_o
);
    wire m_valid;
    wire [3:0] m_st;
    wire [3:0] m_ch;
    wire [6:0] m_d1;
    wire [6:0] m_d2;

    mbcr_msg_parser u_parser (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .byte_valid_i(midi_valid_i),
        .byte_i(midi_byte_i),
        .msg_valid_o(m_valid),
        .msg_status_o(m_st),
        .msg_chan_o(m_ch),
        .msg_d1_o(m_d1),
        .msg_d2_o(m_d2)
    );

    reg edit_reg;
    reg allen_reg;
    reg [3:0] chan_reg;
    reg [3:0] slotsel_reg;
    reg [4:0] slot_cc_reg [0:NSLOT-1];
    reg signed [7:0] amt_reg [0:NSLOT-1];
    reg [6:0] slot_val_reg [0:NSLOT-1];
    reg [3:0] knob_slot_reg [0:NKNOB-1];
    reg [6:0] bank_msb_reg [0:NCH-1];
    reg [6:0] bank_lsb_reg [0:NCH-1];
    reg [6:0] prog_reg [0:NCH-1];
    reg [2:0] mix_reg [0:NCH-1];
    reg [2:0] layer_sel_reg;
    reg [6:0] layer_val_reg [0:3];
    reg [2:0] layer_mix_reg [0:3];
    reg [7:0] name_reg [0:14];
    reg jump_press_reg;
    reg [3:0] jump_btn_reg;
    reg [PAGE_W-1:0] jump_last_reg;
    integer i;
    integer j;

    // Scaled modulation: seven-bit data times signed eight-bit amount.
    function signed [15:0] mbcr_scale;
        input [6:0] val;
        input signed [7:0] amt;
        begin
            mbcr_scale = $signed({2'b00, val}) * amt;
        end
    endfunction

    // Returns the lowest slot whose controller number matches, bit 4 flags a hit.
    function [4:0] mbcr_match;
        input [6:0] cc;
        input [5*NSLOT-1:0] tab;
        integer k;
        begin
            mbcr_match = 5'h00;
            for (k = NSLOT - 1; k >= 0; k = k - 1) begin
                if (cc[6:5] == 2'b00 && tab[5*k +: 5] == cc[4:0]) begin
                    mbcr_match = {1'b1, k[3:0]};
                end
            end
        end
    endfunction

    reg [5*NSLOT-1:0] cc_tab;
    always @* begin
        cc_tab = {5*NSLOT{1'b0}};
        for (j = 0; j < NSLOT; j = j + 1) begin
            cc_tab[5*j +: 5] = slot_cc_reg[j];
        end
    end

    wire [4:0] hit = mbcr_match(m_d1, cc_tab);
    wire is_cc = m_valid && (m_st == `MBCR_ST_CC);
    wire is_pc = m_valid && (m_st == `MBCR_ST_PC);
    wire is_pb = m_valid && (m_st == `MBCR_ST_PB);
    wire is_wr_bank = wr_i && (addr_i == `MBCR_R_BANK);
    wire is_wr_knob = wr_i && (addr_i == `MBCR_R_KNOBVAL);
    wire [1:0] knob_idx = wdata_i[9:8];
    wire [3:0] knob_slot = knob_slot_reg[knob_idx];

    // Fixed destination code: 0 pitch,1 mod,2 pedal,3 volume,4 pan,5 expression, 7 none.
    reg [2:0] fixed_dest;
    always @* begin
        case (m_d1)
            `MBCR_CC_MOD: fixed_dest = 3'h1;
            `MBCR_CC_PEDAL: fixed_dest = 3'h2;
            `MBCR_CC_VOL: fixed_dest = 3'h3;
            `MBCR_CC_PAN: fixed_dest = 3'h4;
            `MBCR_CC_EXPR: fixed_dest = 3'h5;
            default: fixed_dest = 3'h7;
        endcase
    end

    // Layer comparison for the all-layers view.
    wire layers_equal = (layer_val_reg[0] == layer_val_reg[1]) && (layer_val_reg[0] == layer_val_reg[2]) &&
        (layer_val_reg[0] == layer_val_reg[3]);
    wire all_sel = layer_sel_reg[2];
    wire [2:0] ch_mix = mix_reg[chan_reg];
    wire [1:0] cur_layer = all_sel ? 2'b00 : layer_sel_reg[1:0];
    assign layer_send_o = (ch_mix == `MBCR_MIX_PRESET) ? layer_mix_reg[cur_layer] : ch_mix;

    wire [6:0] sel_msb = bank_msb_reg[m_ch];
    wire [6:0] sel_lsb = bank_lsb_reg[m_ch];

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            edit_reg <= 1'b0;
            allen_reg <= 1'b0;
            chan_reg <= 4'h0;
            slotsel_reg <= 4'h0;
            layer_sel_reg <= 3'h0;
            jump_press_reg <= 1'b0;
            jump_btn_reg <= 4'h0;
            jump_last_reg <= {PAGE_W{1'b0}};
            for (i = 0; i < NSLOT; i = i + 1) begin
                slot_cc_reg[i] <= i[4:0] + 5'h10;
                amt_reg[i] <= 8'h00;
                slot_val_reg[i] <= 7'h00;
            end
            for (i = 0; i < NKNOB; i = i + 1) begin
                knob_slot_reg[i] <= i[3:0];
            end
            for (i = 0; i < NCH; i = i + 1) begin
                bank_msb_reg[i] <= 7'h00;
                bank_lsb_reg[i] <= 7'h00;
                prog_reg[i] <= 7'h00;
                mix_reg[i] <= `MBCR_MIX_PRESET;
            end
            for (i = 0; i < 4; i = i + 1) begin
                layer_val_reg[i] <= 7'h00;
                layer_mix_reg[i] <= 3'h0;
            end
            for (i = 0; i < 15; i = i + 1) begin
                name_reg[i] <= 8'h20;
            end
            fixed_valid_o <= 1'b0;
            fixed_chan_o <= 4'h0;
            fixed_dest_o <= 3'h0;
            fixed_value_o <= 14'h0000;
            slot_valid_o <= 1'b0;
            slot_chan_o <= 4'h0;
            slot_idx_o <= 4'h0;
            slot_mod_o <= 16'sh0000;
            prog_valid_o <= 1'b0;
            prog_chan_o <= 4'h0;
            prog_bank_o <= 14'h0000;
            prog_num_o <= 7'h00;
            prog_rom_o <= 1'b0;
            prog_bank_idx_o <= 2'h0;
            prog_bank_known_o <= 1'b0;
            rdata_o <= 32'h00000000;
        end else begin
            fixed_valid_o <= 1'b0;
            slot_valid_o <= 1'b0;
            prog_valid_o <= 1'b0;
            jump_press_reg <= 1'b0;
            // Incoming MIDI messages.
            if (is_pb) begin
                fixed_valid_o <= 1'b1;
                fixed_chan_o <= m_ch;
                fixed_dest_o <= 3'h0;
                fixed_value_o <= {m_d2, m_d1};
            end else if (is_cc) begin
                if (m_d1 == `MBCR_CC_BANK_MSB) begin
                    bank_msb_reg[m_ch] <= m_d2;
                end else if (m_d1 == `MBCR_CC_BANK_LSB) begin
                    bank_lsb_reg[m_ch] <= m_d2;
                end else if (fixed_dest != 3'h7) begin
                    fixed_valid_o <= 1'b1;
                    fixed_chan_o <= m_ch;
                    fixed_dest_o <= fixed_dest;
                    fixed_value_o <= {7'h00, m_d2};
                end else if (hit[4]) begin
                    slot_val_reg[hit[3:0]] <= m_d2;
                    slot_valid_o <= 1'b1;
                    slot_chan_o <= m_ch;
                    slot_idx_o <= hit[3:0];
                    slot_mod_o <= mbcr_scale(m_d2, amt_reg[hit[3:0]]);
                end
            end else if (is_pc && !(edit_reg && m_ch == chan_reg)) begin
                prog_reg[m_ch] <= m_d1;
                prog_valid_o <= 1'b1;
                prog_chan_o <= m_ch;
                prog_bank_o <= {sel_msb, sel_lsb};
                prog_num_o <= m_d1;
                prog_rom_o <= (sel_msb == `MBCR_MSB_ROM);
                prog_bank_idx_o <= sel_lsb[1:0];
                prog_bank_known_o <= ((sel_msb == `MBCR_MSB_USER) || (sel_msb == `MBCR_MSB_ROM)) &&
                    (sel_lsb <= `MBCR_LSB_MAX);
            end
            // Knob movement shares the slot output with MIDI; a knob write in the same cycle as a MIDI slot hit is dropped.
            if (is_wr_knob && knob_slot <= `MBCR_KNOB_SLOT_MAX && !(is_cc && hit[4] && fixed_dest == 3'h7 &&
                m_d1 != `MBCR_CC_BANK_MSB && m_d1 != `MBCR_CC_BANK_LSB)) begin
                slot_val_reg[knob_slot] <= wdata_i[6:0];
                slot_valid_o <= 1'b1;
                slot_chan_o <= chan_reg;
                slot_idx_o <= knob_slot;
                slot_mod_o <= mbcr_scale(wdata_i[6:0], amt_reg[knob_slot]);
            end
            // Register writes from the panel side.
            if (wr_i) begin
                case (addr_i)
                    `MBCR_R_CTRL: begin
                        edit_reg <= wdata_i[`MBCR_CTRL_EDIT];
                        allen_reg <= wdata_i[`MBCR_CTRL_ALLEN];
                        if (!wdata_i[`MBCR_CTRL_ALLEN] && all_sel) begin
                            layer_sel_reg <= 3'h0;
                        end
                    end
                    `MBCR_R_CHAN: chan_reg <= wdata_i[3:0];
                    `MBCR_R_SLOTSEL: slotsel_reg <= wdata_i[3:0];
                    `MBCR_R_SLOTCC: slot_cc_reg[slotsel_reg] <= wdata_i[4:0];
                    `MBCR_R_ROUTE_AMT: amt_reg[slotsel_reg] <= wdata_i[7:0];
                    `MBCR_R_KNOBMAP: begin
                        if (wdata_i[3:0] <= `MBCR_KNOB_SLOT_MAX) begin
                            knob_slot_reg[wdata_i[9:8]] <= wdata_i[3:0];
                        end
                    end
                    `MBCR_R_BANK: begin
                        if (is_wr_bank) begin
                            bank_msb_reg[chan_reg] <= wdata_i[13:7];
                            bank_lsb_reg[chan_reg] <= wdata_i[6:0];
                        end
                    end
                    `MBCR_R_MIXOUT: mix_reg[chan_reg] <= (wdata_i[2:0] > `MBCR_MIX_PRESET) ? `MBCR_MIX_PRESET :
                        wdata_i[2:0];
                    `MBCR_R_LAYERSEL: begin
                        if (!wdata_i[2] || allen_reg) begin
                            layer_sel_reg <= {wdata_i[2], wdata_i[2] ? 2'b00 : wdata_i[1:0]};
                        end
                    end
                    `MBCR_R_LAYERVAL: begin
                        for (i = 0; i < 4; i = i + 1) begin
                            if (all_sel || layer_sel_reg[1:0] == i[1:0]) begin
                                layer_val_reg[i] <= wdata_i[6:0];
                                layer_mix_reg[i] <= wdata_i[10:8];
                            end
                        end
                    end
                    `MBCR_R_JUMP: begin
                        jump_press_reg <= 1'b1;
                        jump_btn_reg <= wdata_i[3:0];
                        jump_last_reg <= wdata_i[8 +: PAGE_W];
                    end
                    `MBCR_R_NAME: begin
                        if (wdata_i[11:8] < 4'hf) begin
                            name_reg[wdata_i[11:8]] <= wdata_i[7:0];
                        end
                    end
                    default: ;
                endcase
            end
            // Read data stands in the cycle after the strobe only.
            rdata_o <= 32'h00000000;
            if (rd_i) begin
                case (addr_i)
                    `MBCR_R_CTRL: rdata_o <= {30'h0, allen_reg, edit_reg};
                    `MBCR_R_CHAN: rdata_o <= {28'h0, chan_reg};
                    `MBCR_R_SLOTSEL: rdata_o <= {28'h0, slotsel_reg};
                    `MBCR_R_SLOTCC: rdata_o <= {27'h0, slot_cc_reg[slotsel_reg]};
                    `MBCR_R_ROUTE_AMT: rdata_o <= {24'h0, amt_reg[slotsel_reg]};
                    `MBCR_R_KNOBMAP: rdata_o <= {knob_slot_reg[3], knob_slot_reg[2], knob_slot_reg[1],
                        knob_slot_reg[0], 16'h0};
                    `MBCR_R_SLOTOUT: rdata_o <= {25'h0, slot_val_reg[slotsel_reg]};
                    `MBCR_R_BANK: rdata_o <= {18'h0, bank_msb_reg[chan_reg], bank_lsb_reg[chan_reg]};
                    `MBCR_R_PROG: rdata_o <= {25'h0, prog_reg[chan_reg]};
                    `MBCR_R_MIXOUT: rdata_o <= {26'h0, layer_send_o, ch_mix};
                    `MBCR_R_LAYERSEL: rdata_o <= {29'h0, layer_sel_reg};
                    `MBCR_R_LAYERVAL: rdata_o <= {15'h0, all_sel && !layers_equal, 5'h0,
                        layer_mix_reg[cur_layer], 1'b0, layer_val_reg[cur_layer]};
                    `MBCR_R_JUMP: rdata_o <= {20'h0, jump_category_o, {(8 - PAGE_W){1'b0}}, jump_page_o};
                    `MBCR_R_NAME: rdata_o <= {name_reg[3], name_reg[2], name_reg[1], name_reg[0]};
                    `MBCR_R_PRESET: rdata_o <= {18'h0, bank_msb_reg[chan_reg], prog_reg[chan_reg]};
                    default: rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    mbcr_jump_stepper #(
        .PAGE_W(PAGE_W)
    ) u_jump (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .press_i(jump_press_reg),
        .button_i(jump_btn_reg),
        .last_page_i(jump_last_reg),
        .category_o(jump_category_o),
        .page_o(jump_page_o)
    );
endmodule
`default_nettype wire

/* File: mbcr_top_sva.sv */
// Port-level assertions for the MIDI bank controller router.
`timescale 1ns/100ps
`default_nettype none
module mbcr_top_sva (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic midi_valid_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic fixed_valid_o,
    input wire logic [2:0] fixed_dest_o,
    input wire logic [13:0] fixed_value_o,
    input wire logic prog_valid_o,
    input wire logic [13:0] prog_bank_o,
    input wire logic prog_rom_o,
    input wire logic [1:0] prog_bank_idx_o,
    input wire logic prog_bank_known_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_bus_idle;
        !rd_i;
    endsequence
    sequence s_prog_known;
        prog_valid_o ##0 prog_bank_known_o;
    endsequence
    AST_FIXED_PULSE: assert property (fixed_valid_o |=> !fixed_valid_o)
        else $error("fixed route pulse longer than one cycle");
    AST_FIXED_SRC: assert property (fixed_valid_o |-> $past(midi_valid_i, 2))
        else $error("fixed route without a byte two cycles before");
    AST_FIXED_DEST: assert property (fixed_valid_o |-> fixed_dest_o <= 3'h5)
        else $error("fixed destination out of range");
    AST_SEVEN_BIT: assert property (fixed_valid_o && fixed_dest_o != 3'h0 |-> fixed_value_o[13:7] == 7'h00)
        else $error("controller value wider than seven bits");
    AST_ROM_BANK: assert property (prog_valid_o && prog_rom_o |-> prog_bank_o[13:7] == 7'h12)
        else $error("rom flag with wrong high byte");
    AST_KNOWN_BANK: assert property (s_prog_known |-> prog_bank_o[6:2] == 5'h00 &&
        prog_bank_o[13:7] inside {7'h00, 7'h12})
        else $error("known bank outside decode table");
    AST_BANK_IDX: assert property (prog_valid_o |-> prog_bank_idx_o == prog_bank_o[1:0])
        else $error("bank index does not follow low byte");
    AST_PROG_SRC: assert property (prog_valid_o |-> $past(midi_valid_i, 2))
        else $error("program select without a byte two cycles before");
    AST_RDATA_IDLE: assert property (s_bus_idle |=> rdata_o == 32'h0000_0000)
        else $error("read data present without a read");
endmodule
bind mbcr_top mbcr_top_sva u_sva (.mclk_i(mclk_i), .resetn_i(resetn_i), .midi_valid_i(midi_valid_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .fixed_valid_o(fixed_valid_o), .fixed_dest_o(fixed_dest_o),
    .fixed_value_o(fixed_value_o), .prog_valid_o(prog_valid_o), .prog_bank_o(prog_bank_o),
    .prog_rom_o(prog_rom_o), .prog_bank_idx_o(prog_bank_idx_o), .prog_bank_known_o(prog_bank_known_o));
`default_nettype wire

/* File: mbcr_midi_kbd.sv */
// Behavioural external MIDI keyboard that sends channel messages one byte per cycle.
`timescale 1ns/100ps
`default_nettype none
module mbcr_midi_kbd (
    input wire logic mclk_i,
    output logic midi_valid_o,
    output logic [7:0] midi_byte_o
);
    initial begin
        midi_valid_o = 1'b0;
        midi_byte_o = 8'h00;
    end
    // Between messages the byte line shows the inverse of the last byte, so stale data never looks valid.
    task automatic send(input logic [7:0] st, input logic [6:0] d1, input logic [6:0] d2, input int n);
        logic [7:0] msg [0:2];
        int i;
        msg[0] = st;
        msg[1] = {1'b0, d1};
        msg[2] = {1'b0, d2};
        for (i = 0; i <= n; i++) begin
            @(posedge mclk_i);
            midi_valid_o <= 1'b1;
            midi_byte_o <= msg[i];
        end
        @(posedge mclk_i);
        midi_valid_o <= 1'b0;
        midi_byte_o <= ~msg[n];
    endtask
endmodule
`default_nettype wire

/* File: mbcr_top_test.sv */
// Self-checking testbench for the MIDI bank controller router.
`timescale 1ns/100ps
`default_nettype none
`include "mbcr_regs.vh"
module mbcr_top_test;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, d;
    logic wr_i = 1'b0, rd_i = 1'b0, midi_valid, fixed_valid_o, slot_valid_o, prog_valid_o, prog_rom_o;
    logic prog_bank_known_o;
    logic [7:0] midi_byte, amt;
    logic [3:0] fixed_chan_o, slot_chan_o, slot_idx_o, prog_chan_o, jump_category_o, ch, k;
    logic [2:0] fixed_dest_o, layer_send_o, jump_page_o;
    logic [13:0] fixed_value_o, prog_bank_o;
    logic signed [15:0] slot_mod_o;
    logic [6:0] prog_num_o, v;
    logic [1:0] prog_bank_idx_o;
    logic [6:0] fcc [0:4] = '{7'h01, 7'h04, 7'h07, 7'h0a, 7'h0b};
    int failures = 0, tests_run = 0, i;
    always #20 mclk_i = ~mclk_i;
    mbcr_midi_kbd u_kbd (.mclk_i(mclk_i), .midi_valid_o(midi_valid), .midi_byte_o(midi_byte));
    mbcr_top u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .midi_valid_i(midi_valid), .midi_byte_i(midi_byte),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .fixed_valid_o(fixed_valid_o), .fixed_chan_o(fixed_chan_o), .fixed_dest_o(fixed_dest_o),
        .fixed_value_o(fixed_value_o), .slot_valid_o(slot_valid_o), .slot_chan_o(slot_chan_o),
        .slot_idx_o(slot_idx_o), .slot_mod_o(slot_mod_o), .prog_valid_o(prog_valid_o), .prog_chan_o(prog_chan_o),
        .prog_bank_o(prog_bank_o), .prog_num_o(prog_num_o), .prog_rom_o(prog_rom_o),
        .prog_bank_idx_o(prog_bank_idx_o), .prog_bank_known_o(prog_bank_known_o), .layer_send_o(layer_send_o),
        .jump_category_o(jump_category_o), .jump_page_o(jump_page_o));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= dat;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dat);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 dat = rdata_o;
    endtask
    // Output pulses stand two edges after the last byte of a message.
    task automatic msg(input logic [7:0] st, input logic [6:0] d1, input logic [6:0] d2, input int n);
        u_kbd.send(st, d1, d2, n);
        @(posedge mclk_i);
        #1;
    endtask
    task automatic prog(input logic [3:0] c, input logic [6:0] n, input logic [13:0] bank, input logic rom, kn);
        msg({4'hc, c}, n, 7'h00, 1);
        check(prog_valid_o, 1'b1);
        check({prog_chan_o, prog_num_o, prog_bank_o}, {c, n, bank});
        check({prog_rom_o, prog_bank_known_o, prog_bank_idx_o}, {rom, kn, bank[1:0]});
    endtask
    function automatic logic signed [15:0] scale(input logic [6:0] val, input logic [7:0] a);
        int p;
        p = int'(val) * int'($signed(a));
        return p[15:0];
    endfunction
    task automatic stop_test;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(40487));
        repeat (12) @(posedge mclk_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 5; i++) begin
            v = 7'($urandom_range(127));
            ch = 4'($urandom_range(15));
            msg({4'hb, ch}, fcc[i], v, 2);
            check({fixed_valid_o, fixed_chan_o, fixed_dest_o}, {1'b1, ch, 3'(i + 1)});
            check(fixed_value_o, {7'h00, v});
        end
        msg(8'he2, 7'h11, 7'h22, 2);
        check({fixed_valid_o, fixed_dest_o, fixed_value_o}, {1'b1, 3'h0, 14'h1111});
        $display("test fixed routes done");
        msg(8'hb3, 7'h00, 7'h12, 2);
        msg(8'hb3, 7'h20, 7'h01, 2);
        prog(4'h3, 7'h05, 14'h0901, 1'b1, 1'b1);
        msg(8'hb3, 7'h20, 7'h02, 2);
        prog(4'h3, 7'h7f, 14'h0902, 1'b1, 1'b1);
        prog(4'h4, 7'h00, 14'h0000, 1'b0, 1'b1);
        msg(8'hb4, 7'h00, 7'h05, 2);
        prog(4'h4, 7'h01, 14'h0280, 1'b0, 1'b0);
        wr(`MBCR_R_CHAN, 32'h3);
        rd(`MBCR_R_BANK, d);
        check(d, 32'h0902);
        wr(`MBCR_R_CTRL, 32'h1);
        msg(8'hc3, 7'h09, 7'h00, 1);
        check(prog_valid_o, 1'b0);
        prog(4'h4, 7'h09, 14'h0280, 1'b0, 1'b0);
        wr(`MBCR_R_CTRL, 32'h0);
        $display("test banks done");
        wr(`MBCR_R_CHAN, 32'h0);
        for (i = 0; i < 6; i++) begin
            k = (i == 0) ? 4'hf : 4'($urandom_range(15));
            amt = (i == 0) ? 8'h80 : 8'($urandom);
            v = (i == 0) ? 7'h7f : 7'($urandom);
            wr(`MBCR_R_SLOTSEL, {28'h0, k});
            wr(`MBCR_R_ROUTE_AMT, {24'h0, amt});
            msg(8'hb0, 7'h10 + 7'(k), v, 2);
            check({slot_valid_o, slot_idx_o}, {1'b1, k});
            check(slot_mod_o, scale(v, amt));
        end
        msg(8'hb0, 7'h28, 7'h33, 2);
        check({slot_valid_o, fixed_valid_o}, 2'b00);
        wr(`MBCR_R_SLOTSEL, 32'h5);
        wr(`MBCR_R_ROUTE_AMT, 32'hfe);
        wr(`MBCR_R_KNOBMAP, 32'h305);
        wr(`MBCR_R_KNOBVAL, 32'h321);
        check({slot_valid_o, slot_chan_o, slot_idx_o}, {1'b1, 4'h0, 4'h5});
        check(slot_mod_o, scale(7'h21, 8'hfe));
        $display("test slots done");
        wr(`MBCR_R_CHAN, 32'h5);
        wr(`MBCR_R_LAYERVAL, 32'h300);
        wr(`MBCR_R_MIXOUT, 32'h2);
        check(layer_send_o, 3'h2);
        wr(`MBCR_R_MIXOUT, 32'h4);
        check(layer_send_o, 3'h3);
        rd(8'hfc, d);
        check(d, 32'h0);
        wr(`MBCR_R_LAYERSEL, 32'h4);
        wr(`MBCR_R_LAYERVAL, 32'h55);
        wr(`MBCR_R_CTRL, 32'h2);
        wr(`MBCR_R_LAYERSEL, 32'h4);
        rd(`MBCR_R_LAYERVAL, d);
        check(d, 32'h10055);
        wr(`MBCR_R_LAYERVAL, 32'h344);
        rd(`MBCR_R_LAYERVAL, d);
        check(d, 32'h344);
        for (i = 0; i < 4; i++) begin
            wr(`MBCR_R_JUMP, 32'h207);
            @(posedge mclk_i) #1 check({jump_category_o, jump_page_o}, {4'h7, 3'(i % 3)});
        end
        $display("test routing done");
        stop_test();
    end
endmodule
`default_nettype wire
